/* File: logic/uart_pkg.sv */
// constants for the oversampled serial transceiver
package uart_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int          ADDR_W   = 3;
   localparam logic [2:0]  A_TXDATA = 3'h0;
   localparam logic [2:0]  A_RXDATA = 3'h1;
   localparam logic [2:0]  A_CTRL   = 3'h2;
   localparam logic [2:0]  A_STATUS = 3'h3;
   localparam logic [2:0]  A_MASK   = 3'h4;

   // status and mask bit positions
   localparam int          ST_TX    = 0;
   localparam int          ST_RX    = 1;
   localparam int          ST_OVR   = 2;
   localparam int          ST_FE    = 3;
   localparam int          ST_W     = 4;
   // control bit positions (busy and full are read only)
   localparam int          CT_FAST  = 0;
   localparam int          CT_BUSY  = 1;
   localparam int          CT_FULL  = 2;

   localparam logic [3:0]  STATUS_RST = 4'h0;
   localparam logic [3:0]  MASK_RST   = 4'h0;
   localparam logic [7:0]  DATA_RST   = 8'h00;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int          CLK_HZ     = 250_000_000;
   localparam int          RC_OSC_HZ  = 87_800;
   localparam int          BAUD_SLOW  = 2400;
   localparam int          FAST_MUL   = 4;
   localparam int          OSR        = 16;
   localparam int          DIV_SLOW_DEF = CLK_HZ / (BAUD_SLOW * OSR);

   // phase index counts from 0, so phase 7 of a bit is index 6
   localparam logic [3:0]  PH_VOTE_LO = 4'h6;
   localparam logic [3:0]  PH_VOTE_HI = 4'h8;
   localparam logic [3:0]  PH_LAST    = 4'hF;
   localparam logic [3:0]  TX_STOP_IX = 4'h9;
   localparam logic [2:0]  RX_LAST_IX = 3'h7;

endpackage

/* File: logic/oversampled_serial_uart.sv */
// serial transceiver on the shared communication pin with register port
//
// Our own choices: the address map and the address-and-strobe port.
module oversampled_serial_uart #(
   parameter int unsigned DIV_SLOW = uart_pkg::DIV_SLOW_DEF
) (
   // clock, reset, enable
   input  wire logic       CLK_SYS_IN,
   input  wire logic       NRST_IN,
   input  wire logic       CE_IN,
   // register port
   input  wire logic [2:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_RD_IN,
   output logic      [7:0] REG_RDATA_OUT,
   // serial communication pin
   input  wire logic       SERIAL_COMM_PIN_IN,
   output logic            SERIAL_COMM_PIN_OUT,
   output logic            SERIAL_COMM_PIN_OE_OUT,
   // interrupt
   output logic            IRQ_OUT
);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

   // ****************************************************************
   // reset release synchroniser, tick divider and majority vote helpers
   // ****************************************************************
   logic rst_s1_q;
   logic rst_n_q;

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   function automatic logic [15:0] tick_div(input logic fast);
      logic [31:0] d;
      d = fast ? DIV_SLOW / uart_pkg::FAST_MUL : DIV_SLOW;
      return d[15:0];
   endfunction

   function automatic logic maj3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   logic       fast_q, fast_d;
   logic [3:0] status_q, status_d;
   logic [3:0] mask_q, mask_d;
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] rxbuf_q, rxbuf_d;
   logic       rx_full_q, rx_full_d;
   logic       tx_busy_q;
   logic       tx_set, rx_done, rx_fe;
   logic [7:0] rx_sr_q;
   logic       wr_tx, rd_rx, rd_st;

   assign wr_tx = REG_WR_IN && REG_ADDR_IN == uart_pkg::A_TXDATA;
   assign rd_rx = REG_RD_IN && REG_ADDR_IN == uart_pkg::A_RXDATA;
   assign rd_st = REG_RD_IN && REG_ADDR_IN == uart_pkg::A_STATUS;

   always_comb
   begin
      fast_d    = fast_q;
      mask_d    = mask_q;
      rdata_d   = 8'h00;
      rxbuf_d   = rxbuf_q;
      rx_full_d = rx_full_q && !rd_rx;
      status_d  = rd_st ? 4'h0 : status_q;
      if (REG_WR_IN && REG_ADDR_IN == uart_pkg::A_CTRL)
         fast_d = REG_WDATA_IN[uart_pkg::CT_FAST];
      if (REG_WR_IN && REG_ADDR_IN == uart_pkg::A_MASK)
         mask_d = REG_WDATA_IN[3:0];
      if (REG_RD_IN)
      begin
         unique case (REG_ADDR_IN)
            uart_pkg::A_RXDATA: rdata_d = rxbuf_q;
            uart_pkg::A_CTRL:   rdata_d = {5'h00, rx_full_q, tx_busy_q, fast_q};
            uart_pkg::A_STATUS: rdata_d = {4'h0, status_q};
            uart_pkg::A_MASK:   rdata_d = {4'h0, mask_q};
            default:            rdata_d = 8'h00;
         endcase
      end
      // events win over the clearing read; flags otherwise hold
      if (tx_set)
         status_d[uart_pkg::ST_TX] = 1'b1;
      if (rx_done)
      begin
         // the held byte is replaced even if unread
         rxbuf_d   = rx_sr_q;
         rx_full_d = 1'b1;
         status_d[uart_pkg::ST_RX] = 1'b1;
         if (rx_full_q && !rd_rx)
            status_d[uart_pkg::ST_OVR] = 1'b1;
         if (rx_fe)
            status_d[uart_pkg::ST_FE] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         fast_q    <= 1'b0;
         status_q  <= uart_pkg::STATUS_RST;
         mask_q    <= uart_pkg::MASK_RST;
         rdata_q   <= uart_pkg::DATA_RST;
         rxbuf_q   <= uart_pkg::DATA_RST;
         rx_full_q <= 1'b0;
      end
      else if (CE_IN)
      begin
         fast_q    <= fast_d;
         status_q  <= status_d;
         mask_q    <= mask_d;
         rdata_q   <= rdata_d;
         rxbuf_q   <= rxbuf_d;
         rx_full_q <= rx_full_d;
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign IRQ_OUT       = |(status_q & mask_q);

   // ****************************************************************
   // transmitter
   // ****************************************************************
   logic [15:0] tx_div_q, tx_div_d;
   logic [3:0]  tx_ph_q, tx_ph_d;
   logic [3:0]  tx_ix_q, tx_ix_d;
   logic [9:0]  tx_fr_q, tx_fr_d;
   logic        tx_busy_d, tx_tick;

   // own divider so sending never waits on the receiver
   assign tx_tick = tx_div_q >= tick_div(fast_q) - 16'h0001;

   always_comb
   begin
      tx_div_d  = tx_tick ? 16'h0000 : tx_div_q + 16'h0001;
      tx_ph_d   = tx_ph_q;
      tx_ix_d   = tx_ix_q;
      tx_fr_d   = tx_fr_q;
      tx_busy_d = tx_busy_q;
      tx_set    = 1'b0;
      if (!tx_busy_q)
      begin
         tx_div_d = 16'h0000;
         // a write while busy is dropped
         if (wr_tx)
         begin
            tx_fr_d   = {1'b1, REG_WDATA_IN, 1'b0};
            tx_busy_d = 1'b1;
            tx_ph_d   = 4'h0;
            tx_ix_d   = 4'h0;
         end
      end
      else if (tx_tick)
      begin
         tx_ph_d = tx_ph_q + 4'h1;
         if (tx_ph_q == uart_pkg::PH_LAST)
         begin
            tx_fr_d = {1'b1, tx_fr_q[9:1]};
            tx_ix_d = tx_ix_q + 4'h1;
            if (tx_ix_q == uart_pkg::TX_STOP_IX)
               tx_busy_d = 1'b0;
            tx_set = tx_ix_q == uart_pkg::TX_STOP_IX - 4'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         tx_div_q  <= 16'h0000;
         tx_ph_q   <= 4'h0;
         tx_ix_q   <= 4'h0;
         tx_fr_q   <= 10'h3FF;
         tx_busy_q <= 1'b0;
      end
      else if (CE_IN)
      begin
         tx_div_q  <= tx_div_d;
         tx_ph_q   <= tx_ph_d;
         tx_ix_q   <= tx_ix_d;
         tx_fr_q   <= tx_fr_d;
         tx_busy_q <= tx_busy_d;
      end
   end

   // the frame register rests at all ones, so the line idles high
   assign SERIAL_COMM_PIN_OUT    = tx_fr_q[0];
   assign SERIAL_COMM_PIN_OE_OUT = tx_busy_q;

   // ****************************************************************
   // receiver
   // ****************************************************************
   rx_state_t   rx_st_q, rx_st_d;
   logic        pin_s1_q, pin_s2_q, pin_s3_q;
   logic [15:0] rx_div_q, rx_div_d;
   logic [3:0]  rx_ph_q, rx_ph_d;
   logic [2:0]  rx_ix_q, rx_ix_d;
   logic [2:0]  vote_q, vote_d;
   logic [7:0]  rx_sr_d;
   logic        rx_tick, bit_v, decide;

   // own pin echoes back while sending; software discards it
   assign rx_tick = rx_div_q >= tick_div(fast_q) - 16'h0001;
   // votes only in phases 7..9, the rest are never looked at
   assign bit_v   = maj3({vote_q[1:0], pin_s3_q});
   assign decide  = rx_tick && rx_ph_q == uart_pkg::PH_VOTE_HI;

   always_comb
   begin
      rx_st_d = rx_st_q;
      rx_div_d = rx_tick ? 16'h0000 : rx_div_q + 16'h0001;
      rx_ph_d = rx_tick ? rx_ph_q + 4'h1 : rx_ph_q;
      rx_ix_d = rx_ix_q;
      vote_d  = vote_q;
      rx_sr_d = rx_sr_q;
      rx_done = 1'b0;
      rx_fe   = 1'b0;
      if (rx_tick && rx_ph_q >= uart_pkg::PH_VOTE_LO && rx_ph_q <= uart_pkg::PH_VOTE_HI)
         vote_d = {vote_q[1:0], pin_s3_q};
      unique case (rx_st_q)
         RX_IDLE:
         begin
            rx_div_d = 16'h0000;
            rx_ph_d  = 4'h0;
            // phases restart at the edge
            if (pin_s3_q && !pin_s2_q)
               rx_st_d = RX_START;
         end
         RX_START:
            if (decide)
            begin
               rx_ix_d = 3'h0;
               rx_st_d = bit_v ? RX_IDLE : RX_DATA;
            end
         RX_DATA:
            if (decide)
            begin
               rx_sr_d = {bit_v, rx_sr_q[7:1]};
               rx_ix_d = rx_ix_q + 3'h1;
               if (rx_ix_q == uart_pkg::RX_LAST_IX)
                  rx_st_d = RX_STOP;
            end
         RX_STOP:
            if (decide)
            begin
               rx_done = 1'b1;
               rx_fe   = !bit_v;
               rx_st_d = RX_IDLE;
            end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pin_s3_q <= 1'b1;
         rx_st_q  <= RX_IDLE;
         rx_div_q <= 16'h0000;
         rx_ph_q  <= 4'h0;
         rx_ix_q  <= 3'h0;
         vote_q   <= 3'h7;
         rx_sr_q  <= uart_pkg::DATA_RST;
      end
      else if (CE_IN)
      begin
         pin_s1_q <= SERIAL_COMM_PIN_IN;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         rx_st_q  <= rx_st_d;
         rx_div_q <= rx_div_d;
         rx_ph_q  <= rx_ph_d;
         rx_ix_q  <= rx_ix_d;
         vote_q   <= vote_d;
         rx_sr_q  <= rx_sr_d;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!rst_n_q);

   AST_TX_START: assert property (CE_IN && wr_tx && !tx_busy_q |=> tx_busy_q)
      else $error("write did not start transmit");
   AST_START_LOW: assert property ($rose(tx_busy_q) |-> !SERIAL_COMM_PIN_OUT)
      else $error("start bit not low");
   AST_IDLE_HIGH: assert property (!tx_busy_q |-> SERIAL_COMM_PIN_OUT)
      else $error("line not high when idle");
   AST_TX_IRQ: assert property (CE_IN && tx_set |=> status_q[0] && SERIAL_COMM_PIN_OUT)
      else $error("tx flag not set with stop bit");
   AST_RX_IRQ: assert property (CE_IN && rx_done |=> status_q[1] && rx_full_q)
      else $error("rx flag or full not set");
   AST_OVERRUN: assert property (CE_IN && rx_done && rx_full_q && !rd_rx |=> status_q[2])
      else $error("overrun not flagged");
   AST_RX_PHASE: assert property (rx_st_q == RX_IDLE ##1 rx_st_q == RX_START
      |-> rx_ph_q == 4'h0 && rx_div_q == 16'h0000)
      else $error("phase not timed from start edge");
   AST_SPIKE: assert property (CE_IN && rx_st_q == RX_START && decide && bit_v
      |=> rx_st_q == RX_IDLE)
      else $error("spike not rejected");

   COV_TX_DONE: cover property ($fell(tx_busy_q));
   COV_RX_DONE: cover property (rx_done && !rx_fe);
   COV_OVR: cover property (rx_done && rx_full_q);

endmodule

/* File: tb/cal_host_model.sv */
// calibration host model on the shared serial communication pin
module cal_host_model (
   input  wire logic clk_in,
   input  wire logic line_in,
   input  wire logic dev_oe_in,
   output logic      drive_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bit_cyc = 128;
   logic [7:0] got_q[$];
   logic [7:0] sh;

   // released line idles high because this model drives it high
   initial drive_out = 1'b1;

   // spike > 0 gives a bare low pulse of that many cycles instead of a frame;
   // spike < 0 sends the frame with a low stop bit, then releases the line
   task automatic send(input logic [7:0] b, input int spike);
      logic [9:0] fr;
      fr = {spike == 0, b, 1'b0}; // start low, lsb first, stop high unless spike < 0
      if (spike > 0)
      begin
         @(posedge clk_in) drive_out <= 1'b0;
         repeat (spike) @(posedge clk_in);
         drive_out <= 1'b1;
      end
      else
      begin
         for (int i = 0; i < 10; i++)
         begin
            @(posedge clk_in) drive_out <= fr[i];
            repeat (bit_cyc - 1) @(posedge clk_in);
         end
         if (spike < 0)
            @(posedge clk_in) drive_out <= 1'b1;
      end
   endtask

   // frames driven by the device are sampled mid-bit
   initial forever
   begin
      @(negedge line_in);
      if (dev_oe_in === 1'b1)
      begin
         repeat (bit_cyc / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++)
         begin
            repeat (bit_cyc) @(posedge clk_in);
            sh[i] = line_in;
         end
         repeat (bit_cyc) @(posedge clk_in);
         if (line_in === 1'b1) got_q.push_back(sh);
      end
   end
endmodule

/* File: tb/oversampled_serial_uart_tb_top.sv */
// self-checking testbench for the oversampled serial transceiver
module oversampled_serial_uart_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 8;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] rdata;
   logic       pin_out;
   logic       pin_oe;
   logic       irq;
   logic       host_drv;
   wire        line = pin_oe ? pin_out : host_drv;
   int         num_errors = 0;
   int         samples_checked = 0;

   always #2 clk = ~clk;

   oversampled_serial_uart #(.DIV_SLOW(DIV)) uut (
      .CLK_SYS_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
      .REG_RDATA_OUT(rdata), .SERIAL_COMM_PIN_IN(line), .SERIAL_COMM_PIN_OUT(pin_out),
      .SERIAL_COMM_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));

   cal_host_model host (.clk_in(clk), .line_in(line), .dev_oe_in(pin_oe), .drive_out(host_drv));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rdchk(input string name, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bus_rd(a, d);
      chk(name, d, exp);
   endtask

   // bounded wait for the pin enable to reach a level; returns cycles spent
   task automatic wait_oe(input logic v, output int n);
      n = 0;
      while (pin_oe !== v && n < 9000)
      begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rdchk("ctrl", uart_pkg::A_CTRL, 8'h00);
      rdchk("status", uart_pkg::A_STATUS, 8'h00);
      rdchk("mask", uart_pkg::A_MASK, 8'h00);
      // a write while the enable is low must leave the mask untouched
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(uart_pkg::A_MASK, 8'h0F);
      ce <= 1'b1;
      rdchk("mask_frozen", uart_pkg::A_MASK, 8'h00);
      rdchk("rxdata", uart_pkg::A_RXDATA, 8'h00);
      rdchk("unmapped", 3'h5, 8'h00);
      chk("idle_line", {7'h00, line}, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_tx_slow;
      int n;
      bus_wr(uart_pkg::A_MASK, 8'h03);
      bus_wr(uart_pkg::A_TXDATA, 8'hA5);
      bus_wr(uart_pkg::A_TXDATA, 8'h0F); // busy, must be dropped
      wait_oe(1'b1, n);
      wait_oe(1'b0, n);
      repeat (4) @(posedge clk);
      chk("tx_count", 8'(host.got_q.size()), 8'h01);
      chk("tx_byte", host.got_q.pop_front(), 8'hA5);
      chk("irq_set", {7'h00, irq}, 8'h01);
      bus_wr(uart_pkg::A_MASK, 8'h00);
      #1 chk("irq_masked", {7'h00, irq}, 8'h00);
      bus_wr(uart_pkg::A_MASK, 8'h03);
      rdchk("status_both", uart_pkg::A_STATUS, 8'h03);
      chk("irq_clear", {7'h00, irq}, 8'h00);
      $display("test tx_slow done");
   endtask

   task automatic t_fast;
      int n;
      int m;
      bus_wr(uart_pkg::A_CTRL, 8'h01);
      host.bit_cyc = 32;
      bus_wr(uart_pkg::A_TXDATA, 8'h3C);
      wait_oe(1'b1, n);
      n = 0;
      while (irq !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("irq_at_stop", 8'(n >= 286 && n <= 290), 8'h01);
      wait_oe(1'b0, m);
      chk("frame_len", 8'(n + m >= 318 && n + m <= 322), 8'h01);
      repeat (4) @(posedge clk);
      chk("fast_byte", host.got_q.pop_front(), 8'h3C);
      // the slow echo was never read, so the fast echo overruns it
      rdchk("status_fast", uart_pkg::A_STATUS, 8'h07);
      host.send(8'hC3, 0);
      rdchk("rx_fast", uart_pkg::A_RXDATA, 8'hC3);
      bus_wr(uart_pkg::A_CTRL, 8'h00);
      host.bit_cyc = 128;
      $display("test fast done");
   endtask

   task automatic t_rx;
      logic [7:0] d;
      bus_rd(uart_pkg::A_RXDATA, d);
      bus_rd(uart_pkg::A_STATUS, d);
      host.send(8'h5A, 0);
      repeat (4) @(posedge clk);
      chk("irq_rx", {7'h00, irq}, 8'h01);
      rdchk("status_rx", uart_pkg::A_STATUS, 8'h02);
      rdchk("rx_byte", uart_pkg::A_RXDATA, 8'h5A);
      host.send(8'h11, 0);
      host.send(8'h22, 0);
      rdchk("rx_over", uart_pkg::A_RXDATA, 8'h22);
      rdchk("status_ovr", uart_pkg::A_STATUS, 8'h06);
      $display("test rx done");
   endtask

   task automatic t_spike;
      host.send(8'h00, 2 * DIV);
      repeat (16 * 10 * DIV) @(posedge clk);
      rdchk("spike", uart_pkg::A_STATUS, 8'h00);
      host.send(8'h81, -1);
      rdchk("status_fe", uart_pkg::A_STATUS, 8'h0A);
      rdchk("rx_fe_byte", uart_pkg::A_RXDATA, 8'h81);
      $display("test spike done");
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_tx_slow();
      t_fast();
      t_rx();
      t_spike();
      close_out();
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      num_errors++;
      close_out();
   end
endmodule
